// file: logic/ioe_params.svh
// constants for the increment/or/move/branch execution block
`ifndef IOE_PARAMS_SVH
`define IOE_PARAMS_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define IOE_DATA_W 8
`define IOE_FADDR_W 7
`define IOE_LIT_W 11
`define IOE_PC_W 13

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define IOE_LATCH_HI 4
`define IOE_LATCH_LO 3
`define IOE_DEST_W 1'b0
`define IOE_DEST_F 1'b1

// ------------------------------------------------------------
// reset values and the increment/zero-compare constants
// ------------------------------------------------------------
`define IOE_W_RST 8'h00
`define IOE_Z_RST 1'b0
`define IOE_PC_RST 13'h0000
`define IOE_ONE 8'h01
`define IOE_ZERO 8'h00

`endif

// file: logic/ioe_pkg.sv
// types shared by the execution block and its datapath
`include "ioe_params.svh"

package ioe_pkg;

	// ------------------------------------------------------------
	// decoded operations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		IOE_NOP = 3'h0,
		increment_skip_if_zero_op = 3'h1,
		unconditional_branch_op = 3'h2,
		or_literal_into_accumulator_op = 3'h3,
		increment_register_op = 3'h4,
		or_accumulator_with_register_op = 3'h5,
		move_register_op = 3'h6
	} ioe_op_t;

	// gray along run -> flush -> run
	typedef enum logic [1:0] {
		IOE_ST_RUN = 2'b00,
		IOE_ST_FLUSH = 2'b01
	} ioe_state_t;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		ioe_op_t op;
		logic dest;
		logic [`IOE_FADDR_W-1:0] faddr;
		logic [`IOE_LIT_W-1:0] lit;
	} ioe_instr_t;

	typedef struct packed {
		logic en;
		logic [`IOE_FADDR_W-1:0] addr;
		logic [`IOE_DATA_W-1:0] data;
	} ioe_fwrite_t;

	typedef struct packed {
		logic [`IOE_DATA_W-1:0] result;
		logic zero;
		logic wr_w;
		logic wr_f;
		logic upd_z;
		logic skip;
		logic branch;
	} ioe_alu_t;

endpackage

// file: logic/ioe_alu.sv
// combinational datapath: result, zero and destination per operation
`timescale 1ns/1ps
`include "ioe_params.svh"

module ioe_alu (
	// operands
	input wire ioe_pkg::ioe_instr_t instr_i,
	input wire logic [`IOE_DATA_W-1:0] w_i,
	input wire logic [`IOE_DATA_W-1:0] f_i,
	// decoded outcome
	output ioe_pkg::ioe_alu_t alu_o
);
	import ioe_pkg::*;

	// destination chosen by the d bit, shared by four operations
	function automatic logic to_file(input logic dest);
		return dest == `IOE_DEST_F;
	endfunction

	// one case per operation; literal or uses only the low byte
	always_comb begin
		alu_o = '0;
		case (instr_i.op)
			increment_skip_if_zero_op: begin
				alu_o.result = f_i + `IOE_ONE;
				alu_o.wr_f = to_file(instr_i.dest);
				alu_o.wr_w = !to_file(instr_i.dest);
				alu_o.skip = (alu_o.result == `IOE_ZERO);
			end
			unconditional_branch_op: begin
				alu_o.branch = 1'b1;
			end
			or_literal_into_accumulator_op: begin
				alu_o.result = w_i | instr_i.lit[`IOE_DATA_W-1:0];
				alu_o.wr_w = 1'b1;
				alu_o.upd_z = 1'b1;
			end
			increment_register_op: begin
				alu_o.result = f_i + `IOE_ONE;
				alu_o.wr_f = to_file(instr_i.dest);
				alu_o.wr_w = !to_file(instr_i.dest);
				alu_o.upd_z = 1'b1;
			end
			or_accumulator_with_register_op: begin
				alu_o.result = w_i | f_i;
				alu_o.wr_f = to_file(instr_i.dest);
				alu_o.wr_w = !to_file(instr_i.dest);
				alu_o.upd_z = 1'b1;
			end
			move_register_op: begin
				alu_o.result = f_i;
				alu_o.wr_f = to_file(instr_i.dest);
				alu_o.wr_w = !to_file(instr_i.dest);
				alu_o.upd_z = 1'b1;
			end
			default: begin
				alu_o = '0;
			end
		endcase
		alu_o.zero = (alu_o.result == `IOE_ZERO);
	end

endmodule

// file: logic/ioe_exec.sv
// execution of increment, or, move and branch operations of the core
`timescale 1ns/1ps
`include "ioe_params.svh"

// Summary of operation
// - skip-increment adds one to f, result to W (d=0) or f (d=1)
// - zero result turns next instruction into a no-op; flags untouched
// - branch loads the eleven-bit literal into pc bits 10..0
// - branch fills pc bits 12..11 from latch bits 4..3
// - branch takes two instruction cycles
// - literal or: W or literal into W, zero flag updated
// - increment adds one to f, routed per d, zero flag, no skip
// - register or: W or f, stored per d, zero flag updated
// - move copies f to W (d=0) or rewrites f unchanged (d=1)
// - move updates zero flag from moved value for either destination
module ioe_exec (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// instruction from the decoder
	input wire logic instr_valid_i,
	input wire ioe_pkg::ioe_instr_t instr_i,
	input wire logic [`IOE_DATA_W-1:0] f_data_i,
	input wire logic [`IOE_DATA_W-1:0] upper_address_latch_i,
	// architectural results
	output logic [`IOE_DATA_W-1:0] w_o,
	output logic z_o,
	output ioe_pkg::ioe_fwrite_t fwr_o,
	// program counter load
	output logic pc_load_o,
	output logic [`IOE_PC_W-1:0] pc_o,
	// sequencing
	output logic done_o,
	output logic nop_cycle_o
);
	import ioe_pkg::*;

	// ------------------------------------------------------------
	// datapath and sequencing state
	// ------------------------------------------------------------
	ioe_alu_t alu;
	ioe_state_t state_reg;
	ioe_state_t state_next;
	logic accept;
	logic [`IOE_DATA_W-1:0] w_reg;
	logic z_reg;
	ioe_fwrite_t fwr_reg;
	logic pc_load_reg;
	logic [`IOE_PC_W-1:0] pc_reg;
	logic done_reg;
	logic nop_reg;

	ioe_alu u_alu (
		.instr_i(instr_i),
		.w_i(w_reg),
		.f_i(f_data_i),
		.alu_o(alu)
	);

	// an instruction offered during a flush cycle is the prefetched
	// one that must be discarded, so it is never accepted
	assign accept = instr_valid_i && (state_reg == IOE_ST_RUN);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// skip and branch both spend one extra cycle as a no-op
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			IOE_ST_RUN: begin
				if (accept && (alu.skip || alu.branch)) begin
					state_next = IOE_ST_FLUSH;
				end
			end
			IOE_ST_FLUSH: begin
				state_next = IOE_ST_RUN;
			end
			default: begin
				state_next = IOE_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= IOE_ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// flush flag kept apart so the output comes from its own flop
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			nop_reg <= 1'b0;
		end else begin
			nop_reg <= (state_next == IOE_ST_FLUSH);
		end
	end

	// one pulse for every executed instruction
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= accept;
		end
	end

	// ------------------------------------------------------------
	// working register and zero flag
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			w_reg <= `IOE_W_RST;
		end else if (accept && alu.wr_w) begin
			w_reg <= alu.result;
		end
	end

	// skip-increment and branch leave upd_z low, flag holds
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			z_reg <= `IOE_Z_RST;
		end else if (accept && alu.upd_z) begin
			z_reg <= alu.zero;
		end
	end

	// ------------------------------------------------------------
	// file register write-back
	// ------------------------------------------------------------
	// move with d=1 writes the same value back; harmless, keeps one path
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fwr_reg <= '0;
		end else begin
			fwr_reg.en <= accept && alu.wr_f;
			fwr_reg.addr <= instr_i.faddr;
			fwr_reg.data <= alu.result;
		end
	end

	// ------------------------------------------------------------
	// program counter load
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pc_load_reg <= 1'b0;
			pc_reg <= `IOE_PC_RST;
		end else begin
			pc_load_reg <= accept && alu.branch;
			if (accept && alu.branch) begin
				pc_reg <= {upper_address_latch_i[`IOE_LATCH_HI:`IOE_LATCH_LO],
					instr_i.lit};
			end
		end
	end

	assign w_o = w_reg;
	assign z_o = z_reg;
	assign fwr_o = fwr_reg;
	assign pc_load_o = pc_load_reg;
	assign pc_o = pc_reg;
	assign done_o = done_reg;
	assign nop_cycle_o = nop_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_skinc_dest;
		@(posedge clk_i) disable iff (rst_i)
		accept && instr_i.op == increment_skip_if_zero_op
		|=> (($past(instr_i.dest) ? fwr_o.data : w_o)
			== $past(f_data_i) + `IOE_ONE)
			&& (fwr_o.en == $past(instr_i.dest));
	endproperty
	a_skinc_dest: assert property (p_skinc_dest)
		else $error("skip-increment result misrouted");

	property p_skip_nop;
		@(posedge clk_i) disable iff (rst_i)
		accept && instr_i.op == increment_skip_if_zero_op
		|=> nop_cycle_o == ($past(f_data_i) == 8'hFF)
			&& $stable(z_o) ##1 !(nop_cycle_o && $past(nop_cycle_o));
	endproperty
	a_skip_nop: assert property (p_skip_nop)
		else $error("skip no-op cycle wrong or flag touched");

	property p_branch_low;
		@(posedge clk_i) disable iff (rst_i)
		accept && instr_i.op == unconditional_branch_op
		|=> pc_load_o && pc_o[`IOE_LIT_W-1:0] == $past(instr_i.lit)
			&& $stable(z_o) && $stable(w_o);
	endproperty
	a_branch_low: assert property (p_branch_low)
		else $error("branch target low bits wrong");

	property p_branch_high;
		@(posedge clk_i) disable iff (rst_i)
		accept && instr_i.op == unconditional_branch_op
		|=> pc_o[`IOE_PC_W-1:`IOE_LIT_W]
			== $past(upper_address_latch_i[`IOE_LATCH_HI:`IOE_LATCH_LO]);
	endproperty
	a_branch_high: assert property (p_branch_high)
		else $error("branch upper pc bits not from latch");

	property p_branch_two;
		@(posedge clk_i) disable iff (rst_i)
		accept && instr_i.op == unconditional_branch_op
		|=> nop_cycle_o && done_o
			##1 !nop_cycle_o && !pc_load_o && !done_o;
	endproperty
	a_branch_two: assert property (p_branch_two)
		else $error("branch did not take two cycles");

	property p_orlit;
		@(posedge clk_i) disable iff (rst_i)
		accept && instr_i.op == or_literal_into_accumulator_op
		|=> w_o == ($past(w_reg) | $past(instr_i.lit[`IOE_DATA_W-1:0]))
			&& z_o == (w_o == 8'h00) && !fwr_o.en;
	endproperty
	a_orlit: assert property (p_orlit)
		else $error("literal or result or zero flag wrong");

	property p_inc;
		@(posedge clk_i) disable iff (rst_i)
		accept && instr_i.op == increment_register_op
		|=> (($past(instr_i.dest) ? fwr_o.data : w_o)
			== $past(f_data_i) + `IOE_ONE)
			&& z_o == ($past(f_data_i) == 8'hFF) && !nop_cycle_o;
	endproperty
	a_inc: assert property (p_inc)
		else $error("increment result or zero flag wrong");

	property p_orreg;
		@(posedge clk_i) disable iff (rst_i)
		accept && instr_i.op == or_accumulator_with_register_op
		|=> (($past(instr_i.dest) ? fwr_o.data : w_o)
			== ($past(w_reg) | $past(f_data_i)))
			&& z_o == (($past(w_reg) | $past(f_data_i)) == 8'h00);
	endproperty
	a_orreg: assert property (p_orreg)
		else $error("register or result or zero flag wrong");

	property p_move;
		@(posedge clk_i) disable iff (rst_i)
		accept && instr_i.op == move_register_op && instr_i.dest
		|=> fwr_o.en && fwr_o.data == $past(f_data_i)
			&& fwr_o.addr == $past(instr_i.faddr) && $stable(w_o);
	endproperty
	a_move: assert property (p_move)
		else $error("self-move did not rewrite the register");

	property p_move_z;
		@(posedge clk_i) disable iff (rst_i)
		accept && instr_i.op == move_register_op
		|=> z_o == ($past(f_data_i) == 8'h00);
	endproperty
	a_move_z: assert property (p_move_z)
		else $error("move did not update zero flag");

	property p_single;
		@(posedge clk_i) disable iff (rst_i)
		accept && !alu.skip && !alu.branch
		|=> done_o && !nop_cycle_o;
	endproperty
	a_single: assert property (p_single)
		else $error("single-cycle operation stalled");

endmodule

// file: verif/tb.sv
// self-checking bench for the increment/or/move/branch execution block
`timescale 1ns/1ps

module tb;
	import ioe_pkg::*;

	// ------------------------------------------------------------
	// stimulus and observation
	// ------------------------------------------------------------
	logic clk_i;
	logic rst_i;
	logic instr_valid_i;
	ioe_instr_t instr_i;
	logic [7:0] f_data_i;
	logic [7:0] upper_address_latch_i;
	logic [7:0] w_o;
	logic z_o;
	ioe_fwrite_t fwr_o;
	logic pc_load_o;
	logic [12:0] pc_o;
	logic done_o;
	logic nop_cycle_o;
	int errors;
	int checked;
	int cycles;

	ioe_exec ioe_exec_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.instr_valid_i(instr_valid_i),
		.instr_i(instr_i),
		.f_data_i(f_data_i),
		.upper_address_latch_i(upper_address_latch_i),
		.w_o(w_o),
		.z_o(z_o),
		.fwr_o(fwr_o),
		.pc_load_o(pc_load_o),
		.pc_o(pc_o),
		.done_o(done_o),
		.nop_cycle_o(nop_cycle_o)
	);

	// 125 MHz core clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// hang guard: the sequence needs well under 200 cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 1000) begin
			errors++;
			report_and_stop();
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(logic [12:0] got, logic [12:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one accepted instruction; nxt offers an or-literal 0xFF right after
	task automatic exec(ioe_op_t op, logic d, logic [7:0] f,
		logic [10:0] lit, logic [7:0] lat, logic nxt);
		@(posedge clk_i);
		instr_valid_i <= 1'b1;
		instr_i <= '{op: op, dest: d, faddr: 7'h7F, lit: lit};
		f_data_i <= f;
		upper_address_latch_i <= lat;
		@(posedge clk_i);
		instr_valid_i <= nxt;
		instr_i.op <= or_literal_into_accumulator_op;
		instr_i.lit <= 11'h0FF;
		#1;
	endtask

	// outputs one cycle after acceptance
	task automatic out(logic [7:0] w, logic z, logic en, logic [7:0] dat,
		logic nop, logic pcl);
		chk(done_o, 1'b1);
		chk(w_o, w);
		chk(z_o, z);
		chk(fwr_o.en, en);
		if (en) begin
			chk(fwr_o.data, dat);
			chk(fwr_o.addr, 7'h7F);
		end
		chk(nop_cycle_o, nop);
		chk(pc_load_o, pcl);
	endtask

	// cycle after: did the offered follower take effect
	task automatic after(logic dn, logic [7:0] w);
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		#1;
		chk(done_o, dn);
		chk(w_o, w);
		chk(pc_load_o, 1'b0);
		chk(nop_cycle_o, 1'b0);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		#1;
		chk(done_o, 1'b0);
		chk(w_o, 8'h00);
		chk(z_o, 1'b0);
		chk(fwr_o.en, 1'b0);
		chk(fwr_o.addr, 7'h00);
		chk(fwr_o.data, 8'h00);
		chk(nop_cycle_o, 1'b0);
		chk(pc_load_o, 1'b0);
		chk(pc_o, 13'h0000);
		$display("test reset done");
	endtask

	task automatic t_move();
		exec(move_register_op, 1'b0, 8'h00, 11'h0, 8'h0, 1'b0);
		out(8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
		exec(move_register_op, 1'b1, 8'h3C, 11'h0, 8'h0, 1'b0);
		out(8'h00, 1'b0, 1'b1, 8'h3C, 1'b0, 1'b0);
		exec(move_register_op, 1'b1, 8'h00, 11'h0, 8'h0, 1'b0);
		out(8'h00, 1'b1, 1'b1, 8'h00, 1'b0, 1'b0);
		$display("test move done");
	endtask

	task automatic t_or_lit();
		exec(or_literal_into_accumulator_op, 1'b0, 8'hAA, 11'h000,
			8'h0, 1'b0);
		out(8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
		exec(or_literal_into_accumulator_op, 1'b1, 8'hAA, 11'h70F,
			8'h0, 1'b0);
		out(8'h0F, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
		exec(or_literal_into_accumulator_op, 1'b0, 8'h00, 11'h0F0,
			8'h0, 1'b0);
		out(8'hFF, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
		$display("test or literal done");
	endtask

	task automatic t_or_reg();
		exec(move_register_op, 1'b0, 8'h00, 11'h0, 8'h0, 1'b0);
		exec(or_accumulator_with_register_op, 1'b1, 8'h00, 11'h0,
			8'h0, 1'b0);
		out(8'h00, 1'b1, 1'b1, 8'h00, 1'b0, 1'b0);
		exec(or_accumulator_with_register_op, 1'b0, 8'hA5, 11'h0,
			8'h0, 1'b0);
		out(8'hA5, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
		exec(or_accumulator_with_register_op, 1'b1, 8'h18, 11'h0,
			8'h0, 1'b0);
		out(8'hA5, 1'b0, 1'b1, 8'hBD, 1'b0, 1'b0);
		$display("test or register done");
	endtask

	task automatic t_incr();
		exec(increment_register_op, 1'b0, 8'hFF, 11'h0, 8'h0, 1'b1);
		out(8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
		after(1'b1, 8'hFF);
		exec(increment_register_op, 1'b1, 8'h7F, 11'h0, 8'h0, 1'b0);
		out(8'hFF, 1'b0, 1'b1, 8'h80, 1'b0, 1'b0);
		$display("test increment done");
	endtask

	// z is 0 on entry, so a zero result must not set it
	task automatic t_skip();
		exec(increment_skip_if_zero_op, 1'b1, 8'hFF, 11'h0, 8'h0, 1'b1);
		out(8'hFF, 1'b0, 1'b1, 8'h00, 1'b1, 1'b0);
		after(1'b0, 8'hFF);
		exec(increment_skip_if_zero_op, 1'b0, 8'h41, 11'h0, 8'h0, 1'b1);
		out(8'h42, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
		after(1'b1, 8'hFF);
		exec(move_register_op, 1'b0, 8'h00, 11'h0, 8'h0, 1'b0);
		exec(increment_skip_if_zero_op, 1'b0, 8'hFF, 11'h0, 8'h0, 1'b1);
		out(8'h00, 1'b1, 1'b0, 8'h00, 1'b1, 1'b0);
		after(1'b0, 8'h00);
		$display("test skip increment done");
	endtask

	task automatic t_branch();
		exec(unconditional_branch_op, 1'b0, 8'h55, 11'h123, 8'h18, 1'b1);
		out(8'h00, 1'b1, 1'b0, 8'h00, 1'b1, 1'b1);
		chk(pc_o, 13'h1923);
		after(1'b0, 8'h00);
		exec(unconditional_branch_op, 1'b1, 8'h55, 11'h7FF, 8'hE7, 1'b0);
		out(8'h00, 1'b1, 1'b0, 8'h00, 1'b1, 1'b1);
		chk(pc_o, 13'h07FF);
		after(1'b0, 8'h00);
		chk(pc_o, 13'h07FF);
		$display("test branch done");
	endtask

	// ------------------------------------------------------------
	// closing
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		errors = 0;
		checked = 0;
		cycles = 0;
		rst_i = 1'b1;
		instr_valid_i = 1'b0;
		instr_i = '0;
		f_data_i = 8'h00;
		upper_address_latch_i = 8'h00;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_move();
		t_or_lit();
		t_or_reg();
		t_incr();
		t_skip();
		t_branch();
		report_and_stop();
	end
endmodule
